/* File: core/tmac_pkg.sv */
// tmac_pkg: constants, register pointers and bus states of the temperature
// monitor alarm and control block.
// assumes a 100 MHz core clock; every cycle count below derives from it.
package tmac_pkg;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int CYC_PER_MS      = 1_000_000 / CLK_PERIOD_NS;
  localparam int CONV_AVG_MS     = 96;
  localparam int CONV_FAST_US    = 15300;
  localparam int BUS_TIMEOUT_MS  = 25;
  localparam int PERIOD_SLOW_MS  = 16000;
  localparam int CONV_AVG_CYC    = CONV_AVG_MS * CYC_PER_MS;
  localparam int CONV_FAST_CYC   = CONV_FAST_US * (CYC_PER_MS / 1000);
  localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_MS * CYC_PER_MS;
  localparam int PERIOD_SLOW_CYC = PERIOD_SLOW_MS * CYC_PER_MS;

  localparam logic [6:0] DEV_ADDR        = 7'h4c;
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;

  localparam logic [7:0] RD_LOCAL   = 8'h00;
  localparam logic [7:0] RD_REMOTE  = 8'h01;
  localparam logic [7:0] RD_STATUS  = 8'h02;
  localparam logic [7:0] RD_CFG     = 8'h03;
  localparam logic [7:0] RD_RATE    = 8'h04;
  localparam logic [7:0] RD_LHI     = 8'h05;
  localparam logic [7:0] RD_LLO     = 8'h06;
  localparam logic [7:0] RD_RHI     = 8'h07;
  localparam logic [7:0] RD_RLO     = 8'h08;
  localparam logic [7:0] WR_CFG     = 8'h09;
  localparam logic [7:0] WR_RATE    = 8'h0a;
  localparam logic [7:0] WR_LHI     = 8'h0b;
  localparam logic [7:0] WR_LLO     = 8'h0c;
  localparam logic [7:0] WR_RHI     = 8'h0d;
  localparam logic [7:0] WR_RLO     = 8'h0e;
  localparam logic [7:0] WR_ONESHOT = 8'h0f;
  localparam logic [7:0] RW_THR     = 8'h19;
  localparam logic [7:0] RW_THL     = 8'h20;
  localparam logic [7:0] RW_HYST    = 8'h21;
  localparam logic [7:0] RW_FCNT    = 8'h22;

  localparam int ST_LHI   = 6;
  localparam int ST_OPEN  = 2;
  localparam int ST_RTH   = 1;
  localparam int ST_LTH   = 0;
  localparam int CFG_GATE = 7;
  localparam int CFG_STBY = 6;
  localparam int FC_TMO   = 7;
  localparam int FC_MSB   = 3;
  localparam int FC_LSB   = 1;

  localparam logic [7:0] CFG_USED  = 8'hc0;
  localparam logic [3:0] RATE_MAX  = 4'ha;
  localparam logic [3:0] RATE_FAST = 4'h9;
  localparam logic [7:0] RST_RATE  = 8'h08;
  localparam logic [7:0] RST_HI    = 8'h55;
  localparam logic [7:0] RST_LO    = 8'h00;
  localparam logic [7:0] RST_OVERTEMP_THROTTLE_N = 8'h55;
  localparam logic [7:0] RST_HYST  = 8'h0a;
  localparam logic [7:0] RST_FCNT  = 8'h01;
  localparam logic [7:0] RST_PTR   = 8'h00;
  localparam logic [7:0] CRC_POLY  = 8'h07;
  localparam logic [2:0] FAULT_MAX = 3'h4;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_BIT   = 4'h9;

  typedef enum logic [5:0] {
    BUS_IDLE  = 6'h01,
    BUS_ADDR  = 6'h02,
    BUS_PTR   = 6'h04,
    BUS_WDATA = 6'h08,
    BUS_READ  = 6'h10,
    BUS_SKIP  = 6'h20
  } tmac_bus_t;
endpackage

/* File: core/tmac_crc8.sv */
// tmac_crc8: one byte step of the packet check sequence, msb first.
// assumes the caller holds the running value in its own register.
`timescale 1ns/100ps
`default_nettype none
module tmac_crc8
  import tmac_pkg::*;
(
  input  wire logic [7:0] crcIn,
  input  wire logic [7:0] dataIn,
  output var  logic [7:0] crcOut
);
  always_comb begin
    crcOut = crcIn ^ dataIn;
    for (int i = 0; i < 8; i++) begin
      crcOut = crcOut[7] ? ({crcOut[6:0], 1'b0} ^ CRC_POLY) : {crcOut[6:0], 1'b0};
    end
  end
endmodule
`default_nettype wire

/* File: core/tmac_monitor.sv */
// tmac_monitor: two-wire slave, limit flags, alarm latch, throttle output
// and conversion sequencing of a local/remote temperature monitor.
// assumes the converter results arrive on core_clk; bus pins are async.
`timescale 1ns/100ps
`default_nettype none
module tmac_monitor
  import tmac_pkg::*;
#(
  parameter int ConvAvgCyc    = CONV_AVG_CYC,
  parameter int ConvFastCyc   = CONV_FAST_CYC,
  parameter int BusTimeoutCyc = BUS_TIMEOUT_CYC,
  parameter int PeriodSlowCyc = PERIOD_SLOW_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output var  logic       sdaOut,
  output var  logic       sdaOeN,
  output var  logic       alertOut,
  output var  logic       alertOeN,
  output var  logic       overtempThrottleN,
  output var  logic       convActive,
  input  wire logic [7:0] localMeas,
  input  wire logic [7:0] remoteMeas,
  input  wire logic       remoteOpen
);
  typedef struct packed {
    logic [2:0]  sclSy;
    logic [2:0]  sdaSy;
    tmac_bus_t   bus;
    logic [3:0]  bitCnt;
    logic [7:0]  shift;
    logic [7:0]  txByte;
    logic [7:0]  ptr;
    logic [7:0]  crc;
    logic        dataDone;
    logic        pecSent;
    logic        sdaOeN;
    logic [31:0] tmo;
    logic [7:0]  cfg;
    logic [7:0]  rate;
    logic [7:0]  hiL;
    logic [7:0]  loL;
    logic [7:0]  hiR;
    logic [7:0]  loR;
    logic [7:0]  thR;
    logic [7:0]  thL;
    logic [7:0]  hyst;
    logic [7:0]  fcnt;
    logic [7:0]  locVal;
    logic [7:0]  remVal;
    logic        openQ;
    logic [6:0]  flags;
    logic        alertLatch;
    logic        alertOeN;
    logic        otN;
    logic        busy;
    logic [31:0] convCnt;
    logic [31:0] perCnt;
    logic [2:0]  faultL;
    logic [2:0]  faultR;
  } tmac_state_t;

  localparam tmac_state_t ST_RESET = '{
    sclSy: 3'h7, sdaSy: 3'h7, bus: BUS_IDLE, ptr: RST_PTR, sdaOeN: 1'b1,
    rate: RST_RATE, hiL: RST_HI, loL: RST_LO, hiR: RST_HI, loR: RST_LO,
    thR: RST_OVERTEMP_THROTTLE_N, thL: RST_OVERTEMP_THROTTLE_N, hyst: RST_HYST, fcnt: RST_FCNT,
    alertOeN: 1'b1, otN: 1'b1, default: '0};

  tmac_state_t q;
  tmac_state_t d;
  logic        sclRise;
  logic        sclFall;
  logic        startC;
  logic        stopC;
  logic        tmoHit;
  logic        statusRd;
  logic        araHit;
  logic        araClr;
  logic        regWr;
  logic        oneShotWr;
  logic        convDone;
  logic        startConv;
  logic        standby;
  logic [7:0]  rdVal;
  logic [7:0]  crcByte;
  logic [7:0]  crcOut;
  logic [3:0]  rateEff;
  logic [31:0] convLen;
  logic [1:0]  newL;
  logic [1:0]  newR;
  logic [1:0]  presL;
  logic [1:0]  presR;
  logic [4:0]  keep;
  logic [4:0]  setMask;
  logic [2:0]  need;

  // {above high limit, at or below low limit}
  function automatic logic [1:0] trips(input logic [7:0] v, input logic [7:0] hi,
                                       input logic [7:0] lo);
    trips = {v > hi, v <= lo};
  endfunction

  // saturating count of consecutive out-of-limit results
  function automatic logic [2:0] bump(input logic [2:0] cnt, input logic hit);
    bump = !hit ? 3'h0 : (cnt == FAULT_MAX) ? cnt : cnt + 3'h1;
  endfunction

  // thermometer code 000/001/011/111 gives one to four
  function automatic logic [2:0] faultNeed(input logic [2:0] code);
    faultNeed = code[2] ? 3'h4 : code[1] ? 3'h3 : code[0] ? 3'h2 : 3'h1;
  endfunction

  // widened so reading plus hysteresis cannot wrap past 255
  function automatic logic thermNext(input logic cur, input logic [7:0] v,
                                     input logic [7:0] lim, input logic [7:0] hy);
    if (v > lim) begin
      thermNext = 1'b1;
    end else if ({1'b0, v} + {1'b0, hy} < {1'b0, lim}) begin
      thermNext = 1'b0;
    end else begin
      thermNext = cur;
    end
  endfunction

  assign crcByte = (q.bus == BUS_READ) ? q.txByte : q.shift;

  tmac_crc8 u_crc (
    .crcIn  (q.crc),
    .dataIn (crcByte),
    .crcOut (crcOut)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d         = q;
    d.sclSy   = {q.sclSy[1:0], sclIn};
    d.sdaSy   = {q.sdaSy[1:0], sdaIn};
    sclRise   = q.sclSy[1] & ~q.sclSy[2];
    sclFall   = ~q.sclSy[1] & q.sclSy[2];
    startC    = q.sclSy[1] & q.sclSy[2] & ~q.sdaSy[1] & q.sdaSy[2];
    stopC     = q.sclSy[1] & q.sclSy[2] & q.sdaSy[1] & ~q.sdaSy[2];
    statusRd  = 1'b0;
    araHit    = 1'b0;
    regWr     = 1'b0;
    oneShotWr = 1'b0;
    tmoHit    = 1'b0;
    case (q.ptr)
      RD_LOCAL:  rdVal = q.locVal;
      RD_REMOTE: rdVal = q.remVal;
      RD_STATUS: rdVal = {q.busy, q.flags};
      RD_CFG:    rdVal = q.cfg;
      RD_RATE:   rdVal = q.rate;
      RD_LHI:    rdVal = q.hiL;
      RD_LLO:    rdVal = q.loL;
      RD_RHI:    rdVal = q.hiR;
      RD_RLO:    rdVal = q.loR;
      RW_THR:    rdVal = q.thR;
      RW_THL:    rdVal = q.thL;
      RW_HYST:   rdVal = q.hyst;
      RW_FCNT:   rdVal = q.fcnt;
      default:   rdVal = 8'h00;
    endcase

    // idle counter restarts on each clock edge, start or stop, so only a stall of the whole timeout cuts a host off
    if (q.bus == BUS_IDLE || sclRise || sclFall || startC || stopC) begin
      d.tmo = '0;
    end else begin
      d.tmo  = q.tmo + 32'h1;
      tmoHit = q.fcnt[FC_TMO] && (q.tmo >= 32'(BusTimeoutCyc - 1));
    end

    // the bus keeps running whatever the mode
    if (startC) begin
      d.bus      = BUS_ADDR;
      d.bitCnt   = '0;
      d.sdaOeN   = 1'b1;
      d.dataDone = 1'b0;
      d.pecSent  = 1'b0;
      if (q.bus == BUS_IDLE) begin
        d.crc = '0;
      end
    end else if (stopC || tmoHit) begin
      d.bus    = BUS_IDLE;
      d.sdaOeN = 1'b1;
    end else if (q.bus != BUS_IDLE && q.bus != BUS_SKIP) begin
      if (sclRise) begin
        d.shift  = {q.shift[6:0], q.sdaSy[1]};
        d.bitCnt = q.bitCnt + 4'h1;
      end
      if (sclFall && q.bitCnt == BYTE_BITS) begin
        if (q.bus == BUS_READ) begin
          d.sdaOeN = 1'b1;
        end else begin
          d.crc    = crcOut;
          d.sdaOeN = 1'b0;
          unique case (q.bus)
            BUS_ADDR: begin
              if (q.shift[7:1] == DEV_ADDR) begin
                d.bus    = q.shift[0] ? BUS_READ : BUS_PTR;
                d.txByte = rdVal;
                statusRd = q.shift[0] && (q.ptr == RD_STATUS);
              end else if (q.shift[7:1] == ALERT_RESP_ADDR && q.shift[0] && q.alertLatch) begin
                d.bus    = BUS_READ;
                d.txByte = {DEV_ADDR, 1'b0};
                araHit   = 1'b1;
              end else begin
                d.bus    = BUS_SKIP;
                d.sdaOeN = 1'b1;
              end
            end
            BUS_PTR: begin
              d.ptr = q.shift;
              d.bus = BUS_WDATA;
            end
            BUS_WDATA: begin
              // a byte after the data byte is the packet check; taken, not stored
              regWr      = ~q.dataDone;
              d.dataDone = 1'b1;
            end
          endcase
        end
      end else if (sclFall && q.bitCnt == ACK_BIT) begin
        d.bitCnt = '0;
        d.sdaOeN = 1'b1;
        if (q.bus == BUS_READ) begin
          if (q.shift[0]) begin
            d.bus = BUS_SKIP;
          end else if (!q.dataDone) begin
            d.sdaOeN   = q.txByte[7];
            d.dataDone = 1'b1;
            d.crc      = crcOut;
          end else begin
            d.txByte  = q.pecSent ? 8'hff : q.crc;
            d.sdaOeN  = d.txByte[7];
            d.pecSent = 1'b1;
          end
        end
      end else if (sclFall && q.bus == BUS_READ) begin
        d.txByte = {q.txByte[6:0], 1'b1};
        d.sdaOeN = q.txByte[6];
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    if (regWr) begin
      case (q.ptr)
        WR_CFG:     d.cfg = q.shift & CFG_USED;
        WR_RATE:    d.rate = q.shift;
        WR_LHI:     d.hiL = q.shift;
        WR_LLO:     d.loL = q.shift;
        WR_RHI:     d.hiR = q.shift;
        WR_RLO:     d.loR = q.shift;
        WR_ONESHOT: oneShotWr = 1'b1;
        RW_THR:     d.thR = q.shift;
        RW_THL:     d.thL = q.shift;
        RW_HYST:    d.hyst = q.shift;
        RW_FCNT:    d.fcnt = q.shift;
        default:    ;
      endcase
    end

    // reserved codes 0b to 0f run at the fastest rate; the upper nibble is not decoded
    rateEff  = (q.rate[3:0] > RATE_MAX) ? RATE_MAX : q.rate[3:0];
    convLen  = (rateEff >= RATE_FAST) ? 32'(ConvFastCyc) : 32'(ConvAvgCyc);
    convDone = q.busy && (q.convCnt == '0);
    standby  = q.cfg[CFG_STBY];
    if (q.busy) begin
      d.convCnt = q.convCnt - 32'h1;
      d.busy    = !convDone;
    end
    startConv = 1'b0;
    if (!standby) begin
      if (q.perCnt == '0) begin
        d.perCnt  = (32'(PeriodSlowCyc) >> rateEff) - 32'h1;
        startConv = !q.busy;
      end else begin
        d.perCnt = q.perCnt - 32'h1;
      end
    end else begin
      d.perCnt  = '0;
      startConv = oneShotWr && !q.busy;
    end
    if (startConv) begin
      d.busy    = 1'b1;
      d.convCnt = convLen - 32'h1;
    end

    ////////////////////////////////////////////////////////////////////////////
    newL    = trips(localMeas, q.hiL, q.loL);
    newR    = trips(remoteMeas, q.hiR, q.loR);
    presL   = trips(q.locVal, q.hiL, q.loL);
    presR   = trips(q.remVal, q.hiR, q.loR);
    need    = faultNeed(q.fcnt[FC_MSB:FC_LSB]);
    setMask = '0;
    if (convDone) begin
      d.locVal = localMeas;
      d.remVal = remoteMeas;
      d.openQ  = remoteOpen;
      d.faultL = bump(q.faultL, |newL);
      d.faultR = bump(q.faultR, |newR);
      setMask  = {newL & {2{d.faultL >= need}}, newR & {2{d.faultR >= need}},
                  remoteOpen};
      d.flags[ST_RTH] = thermNext(q.flags[ST_RTH], remoteMeas, q.thR, q.hyst);
      d.flags[ST_LTH] = thermNext(q.flags[ST_LTH], localMeas, q.thL, q.hyst);
    end
    // a live cause, or a new trip in the same cycle, beats the read-clear
    keep = statusRd ? {presL, presR, q.openQ} : 5'h1f;
    d.flags[ST_LHI:ST_OPEN] = (q.flags[ST_LHI:ST_OPEN] & keep) | setMask;

    araClr       = araHit && !(|q.flags[ST_LHI:ST_OPEN]);
    d.alertLatch = (q.alertLatch && !araClr) || (|q.flags[ST_LHI:ST_OPEN]);
    d.alertOeN   = !(q.alertLatch && !q.cfg[CFG_GATE]);
    d.otN        = !(d.flags[ST_RTH] || d.flags[ST_LTH]);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      q <= ST_RESET;
    end else begin
      q <= d;
    end
  end

  // open-drain pins only ever pull low
  assign sdaOut            = 1'b0;
  assign alertOut          = 1'b0;
  assign sdaOeN            = q.sdaOeN;
  assign alertOeN          = q.alertOeN;
  assign overtempThrottleN = q.otN;
  assign convActive        = q.busy;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  busy_bit_a: assert property (statusRd |-> ##1 q.txByte[7] == $past(q.busy))
    else $error("status bit 7 does not show conversion state");
  high_trip_a: assert property (convDone && need == 3'h1 && localMeas > q.hiL
    |=> q.flags[ST_LHI])
    else $error("local high trip not flagged");
  low_trip_a: assert property (convDone && need == 3'h1 && remoteMeas <= q.loR
    |=> q.flags[ST_OPEN+1])
    else $error("remote low trip not flagged");
  open_flag_a: assert property (convDone && remoteOpen |=> q.flags[ST_OPEN])
    else $error("open sensor not flagged");
  latch_set_a: assert property ((|q.flags[ST_LHI:ST_OPEN]) |=> q.alertLatch)
    else $error("alarm latch not set by flag");
  alert_pin_a: assert property (q.alertLatch && !q.cfg[CFG_GATE] |=> !q.alertOeN)
    else $error("alarm pin not pulled low");
  alert_mask_a: assert property (q.cfg[CFG_GATE] |=> q.alertOeN)
    else $error("masked alarm pin still driven");
  read_clear_a: assert property (statusRd && !presL[1] && !convDone
    |=> !q.flags[ST_LHI])
    else $error("stale flag survived status read");
  flag_hold_a: assert property (q.flags[ST_LHI] && presL[1] |=> q.flags[ST_LHI])
    else $error("flag cleared with cause present");
  latch_keep_a: assert property (statusRd && q.alertLatch |=> q.alertLatch)
    else $error("status read cleared alarm latch");
  overtemp_throttle_n_pin_a: assert property (q.otN == !(q.flags[ST_RTH] || q.flags[ST_LTH]))
    else $error("throttle pin disagrees with flags");
  overtemp_throttle_n_hyst_a: assert property (convDone && q.flags[ST_LTH]
    && ({1'b0, localMeas} + {1'b0, q.hyst} >= {1'b0, q.thL}) |=> q.flags[ST_LTH])
    else $error("throttle flag dropped inside hysteresis");
  standby_a: assert property ($rose(q.busy) |-> !$past(standby) || $past(oneShotWr))
    else $error("conversion started in standby");
  conv_avg_a: assert property (startConv && rateEff < RATE_FAST
    |=> q.convCnt == 32'(ConvAvgCyc - 1))
    else $error("averaged conversion length wrong");
  conv_fast_a: assert property (startConv && rateEff >= RATE_FAST
    |=> q.convCnt == 32'(ConvFastCyc - 1))
    else $error("fast conversion length wrong");
  bus_timeout_a: assert property (tmoHit |=> q.bus == BUS_IDLE && q.sdaOeN)
    else $error("timeout left bus engaged");
  ptr_load_a: assert property (q.bus == BUS_PTR && sclFall && q.bitCnt == BYTE_BITS
    |=> q.ptr == $past(q.shift))
    else $error("pointer not loaded from first byte");

  conv_c: cover property ($rose(q.busy) ##[1:20] convDone);
  ara_c: cover property (araHit ##1 !q.alertLatch);
  tmo_c: cover property (tmoHit);
  clr_c: cover property (statusRd && (|q.flags[ST_LHI:ST_OPEN]));
endmodule
`default_nettype wire

/* File: verification/tmac_host.sv */
// tmac_host: two-wire bus master model, drives the clock and pulls data low.
// assumes the bench resolves the data wire from both open-drain enables.
`timescale 1ns/100ps
`default_nettype none
module tmac_host (
  input  wire logic core_clk,
  input  wire logic sdaLine,
  output var  logic sclOut,
  output var  logic sdaDrvN
);
  initial begin
    sclOut  = 1'b1;
    sdaDrvN = 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // 60 ns low, 20 ns high: the long low phase covers the slave's synchroniser lag
  task automatic bitIo(input logic b, output logic r);
    cyc(1);
    sdaDrvN <= b;
    cyc(5);
    sclOut <= 1'b1;
    cyc(1);
    r = sdaLine;
    cyc(1);
    sclOut <= 1'b0;
  endtask
  task automatic start();
    cyc(1);
    sdaDrvN <= 1'b1;
    cyc(7);
    sclOut <= 1'b1;
    cyc(4);
    sdaDrvN <= 1'b0;
    cyc(4);
    sclOut <= 1'b0;
  endtask
  task automatic stop();
    cyc(1);
    sdaDrvN <= 1'b0;
    cyc(7);
    sclOut <= 1'b1;
    cyc(4);
    sdaDrvN <= 1'b1;
    cyc(4);
  endtask
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitIo(d[i], r);
    bitIo(1'b1, r);
    ack = ~r;
  endtask
  // nack high ends a read; low asks for one more byte
  task automatic rx(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitIo(1'b1, r);
      d[i] = r;
    end
    bitIo(nack, r);
  endtask
endmodule
`default_nettype wire

/* File: verification/tmac_monitor_bench.sv */
// tmac_monitor_bench: self-checking bench of the monitor through its bus pins.
// assumes tmac_host as bus master and a pull-up on the data wire.
`timescale 1ns/100ps
`default_nettype none
module tmac_monitor_bench
  import tmac_pkg::*;
;
  localparam int AvgCyc  = 40;
  localparam int FastCyc = 20;
  logic       core_clk;
  logic       sys_rst;
  logic       sclIn;
  logic       sdaDrvN;
  logic       sdaOeN;
  logic       sdaLine;
  logic       alertOeN;
  logic       overtempThrottleN;
  logic       convActive;
  logic [7:0] localMeas;
  logic [7:0] remoteMeas;
  logic       remoteOpen;
  int         errors  = 0;
  int         nTests  = 0;
  int         busyCnt = 0;
  assign sdaLine = sdaOeN & sdaDrvN;
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (convActive === 1'b1) busyCnt <= busyCnt + 1;
  tmac_monitor #(.ConvAvgCyc(AvgCyc), .ConvFastCyc(FastCyc), .BusTimeoutCyc(200),
    .PeriodSlowCyc(65536)) u_tmac_monitor (
    .core_clk(core_clk), .sys_rst(sys_rst), .sclIn(sclIn), .sdaIn(sdaLine),
    .sdaOut(), .sdaOeN(sdaOeN), .alertOut(), .alertOeN(alertOeN),
    .overtempThrottleN(overtempThrottleN), .convActive(convActive),
    .localMeas(localMeas), .remoteMeas(remoteMeas), .remoteOpen(remoteOpen));
  tmac_host u_tmac_host (.core_clk(core_clk), .sdaLine(sdaLine), .sclOut(sclIn),
    .sdaDrvN(sdaDrvN));
  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    nTests++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [15:0] m);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task automatic tx(input logic [7:0] d);
    logic a;
    u_tmac_host.tx(d, a);
    chk1(a, 1'b1);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    u_tmac_host.start();
    tx({DEV_ADDR, 1'b0});
    tx(p);
    tx(v);
    u_tmac_host.stop();
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    u_tmac_host.start();
    tx({DEV_ADDR, 1'b0});
    tx(p);
    u_tmac_host.start();
    tx({DEV_ADDR, 1'b1});
    u_tmac_host.rx(1'b1, d);
    u_tmac_host.stop();
  endtask
  // 600 cycles hold at least one full conversion at rate code 08
  task automatic setMeas(input logic [7:0] l, input logic [7:0] r, input logic o);
    @(posedge core_clk);
    localMeas  <= l;
    remoteMeas <= r;
    remoteOpen <= o;
    cyc(600);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_resetVals;
    logic [7:0] d;
    rd(RD_CFG, d);
    chk8(d, 8'h00);
    rd(RD_RATE, d);
    chk8(d, 8'h08);
    rd(RW_FCNT, d);
    chk8(d, 8'h01);
    rd(RW_HYST, d);
    chk8(d, 8'h0a);
    wr(RW_HYST, 8'h05);
    rd(RW_HYST, d);
    chk8(d, 8'h05);
    wr(RW_HYST, 8'h0a);
  endtask
  // pointer left at the hysteresis register by the previous scenario
  task automatic t_pec;
    logic [7:0] d;
    logic [7:0] c;
    u_tmac_host.start();
    tx({DEV_ADDR, 1'b1});
    u_tmac_host.rx(1'b0, d);
    u_tmac_host.rx(1'b1, c);
    u_tmac_host.stop();
    chk8(d, 8'h0a);
    chk8(c, crc8({DEV_ADDR, 1'b1, 8'h0a}));
  endtask
  task automatic t_limits;
    logic [7:0] d;
    setMeas(8'h56, 8'h00, 1'b1);
    rd(RD_STATUS, d);
    chk8(d & 8'h7f, 8'h4d);
    rd(RD_STATUS, d);
    chk8(d & 8'h7f, 8'h4d);
    chk1(alertOeN, 1'b0);
    chk1(overtempThrottleN, 1'b0);
    setMeas(8'h50, 8'h20, 1'b0);
    chk1(overtempThrottleN, 1'b0);
    setMeas(8'h40, 8'h20, 1'b0);
    chk1(overtempThrottleN, 1'b1);
    rd(RD_STATUS, d);
    rd(RD_STATUS, d);
    chk8(d & 8'h7f, 8'h00);
    chk1(alertOeN, 1'b0);
    u_tmac_host.start();
    tx({ALERT_RESP_ADDR, 1'b1});
    u_tmac_host.rx(1'b1, d);
    u_tmac_host.stop();
    chk8(d, {DEV_ADDR, 1'b0});
    cyc(8);
    chk1(alertOeN, 1'b1);
  endtask
  task automatic t_standby;
    logic [7:0] d;
    int         b0;
    wr(WR_CFG, 8'hc0);
    cyc(400);
    b0 = busyCnt;
    cyc(300);
    chk8(8'(busyCnt - b0), 8'h00);
    rd(RD_CFG, d);
    chk8(d, 8'hc0);
    setMeas(8'h56, 8'h20, 1'b0);
    b0 = busyCnt;
    wr(WR_ONESHOT, 8'h5a);
    cyc(100);
    chk8(8'(busyCnt - b0), 8'(AvgCyc));
    chk1(overtempThrottleN, 1'b0);
    chk1(alertOeN, 1'b1);
    wr(WR_CFG, 8'h40);
    cyc(4);
    chk1(alertOeN, 1'b0);
    wr(WR_RATE, 8'h09); // upper nibble left zero
    b0 = busyCnt;
    wr(WR_ONESHOT, 8'h00);
    cyc(100);
    chk8(8'(busyCnt - b0), 8'(FastCyc));
  endtask
  // still in standby: each one-shot gives exactly one result to the filter
  task automatic t_fault;
    logic [7:0] d;
    setMeas(8'h20, 8'h20, 1'b0);
    wr(WR_ONESHOT, 8'h00);
    cyc(100);
    rd(RD_STATUS, d);
    wr(RW_FCNT, 8'h02);
    setMeas(8'h56, 8'h20, 1'b0);
    wr(WR_ONESHOT, 8'h00);
    cyc(100);
    rd(RD_STATUS, d);
    chk8(d & 8'h7f, 8'h01);
    wr(WR_ONESHOT, 8'h00);
    cyc(100);
    rd(RD_STATUS, d);
    chk8(d & 8'h7f, 8'h41);
  endtask
  // host stalls inside the ack bit: kept without the timeout, dropped with it
  task automatic t_timeout;
    logic       r;
    logic [7:0] a;
    a = {DEV_ADDR, 1'b0};
    for (int k = 0; k < 2; k++) begin
      if (k == 1) wr(RW_FCNT, 8'h80);
      u_tmac_host.start();
      for (int i = 7; i >= 0; i--) u_tmac_host.bitIo(a[i], r);
      cyc(300);
      chk1(sdaOeN, k == 1);
      u_tmac_host.bitIo(1'b1, r);
      u_tmac_host.stop();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", errors, nTests);
    if (errors == 0 && nTests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    sys_rst    = 1'b1;
    localMeas  = 8'h20;
    remoteMeas = 8'h20;
    remoteOpen = 1'b0;
    cyc(16);
    sys_rst <= 1'b0;
    cyc(8);
    t_resetVals;
    t_pec;
    t_limits;
    t_standby;
    t_fault;
    t_timeout;
    tally_and_finish;
  end
  // whole run needs about 13400 cycles
  initial begin
    cyc(40000);
    errors++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
